// ==== rx_qual_pkg.sv ====
// constants and carrier types for the receive port video qualifier
// assumes a single core clock and an 8-bit register access port
// Notes on behaviour
// - eight-bit count of errored packets since last read; reading clears it.
// - port registers answer only when selected by port-select register 0x4C.
// - narrowing field: 00 normal, 01 reserved, 10 upper eight, 11 lower eight.
// - narrowing in ten-bit raw mode makes pixels eight-bit and packed so.
// - parity-discard bit (default one) truncates frame on parity error, else forwards.
// - line-size discard bit truncates frame when line length changes.
// - frame-size discard bit restarts the qualification frame count when lines per frame change; no frame is truncated.
// - after a frame-size change with qualified-discard set, forwarding resumes once frame threshold is met.
// - automatic polarity bit learns line and frame valid sense from video.
// - automatic polarity drops at least the first received frame.
// - without automatic polarity, sense comes from the two programmed bits.
// - line valid sense one means line valid is low during video.
// - frame valid sense one means frame valid is low during video.
// - qualified-discard bit drops packets while port is not qualified.
// - clear-count bit zeroes line metrics readback while unqualified.
// - qualified follows lock at threshold zero, else after threshold valid frames.
// - line length readback shows most recent received line length.
package rx_qual_pkg;
   localparam logic [7:0] PORT_SELECT_ADDR  = 8'h4c;
   localparam logic [7:0] ERR_TALLY_ADDR    = 8'h7b;
   localparam logic [7:0] VIDEO_CONFIG_ADDR = 8'h7c;
   localparam logic [7:0] QUAL_CONTROL_ADDR = 8'h7d;
   localparam logic [7:0] PORT_SELECT_RESET = 8'h01;
   localparam logic [7:0] VIDEO_CONFIG_RESET = 8'h20;
   localparam logic [7:0] QUAL_CONTROL_RESET = 8'h00;
   localparam logic [7:0] TALLY_MAX          = 8'hff;
   // video config fields
   localparam int NARROW_HI    = 7;
   localparam int NARROW_LO    = 6;
   localparam int PARITY_DROP  = 5;
   localparam int LINE_DROP    = 4;
   localparam int FRAME_DROP   = 3;
   localparam int AUTO_SENSE   = 2;
   localparam int LINE_SENSE   = 1;
   localparam int FRAME_SENSE  = 0;
   // qualify control fields
   localparam int QUAL_DROP    = 7;
   localparam int ZERO_METRICS = 6;
   localparam int THRESH_HI    = 1;
   localparam int THRESH_LO    = 0;
   localparam logic [1:0] NARROW_UPPER = 2'b10;
   localparam logic [1:0] NARROW_LOWER = 2'b11;
   localparam int FIFO_DEPTH = 4;

   typedef struct packed {
      logic       sof;
      logic       sol;
      logic       eight_bit;
      logic [9:0] data;
   } pixel_word_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {
      FRAME_IDLE   = 2'b00,
      FRAME_ACTIVE = 2'b01,
      FRAME_TRUNC  = 2'b10
   } frame_state_t;
endpackage

// ==== video_fifo.sv ====
// small fifo with registered output stage and registered full flag
// assumes one clock; depth a power of two
`timescale 1ns/1ps
`default_nettype none
module video_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 4
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign push = in_valid & in_ready;
   assign pop = (count != '0) & (~out_valid | out_ready);
   assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         count <= next_count;
         // registered full keeps the ready path free of logic
         in_ready <= (next_count != DEPTH[AW:0]);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (pop) begin
         out_valid <= 1'b1;
         out_data <= mem[rd_ptr];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule // video_fifo
`default_nettype wire

// ==== rx_port_video_qualifier.sv ====
// one receive port: error tally, polarity, narrowing, truncation, qualification
// assumes video, lock and fault inputs come from receiver logic on this clock
`timescale 1ns/1ps
`default_nettype none
module rx_port_video_qualifier
   import rx_qual_pkg::*;
#(
   parameter int PORT_INDEX = 0,
   parameter int LEN_W      = 16
) (
   input  wire logic                      clock,
   input  wire logic                      rst,
   input  wire rx_qual_pkg::reg_req_t     reg_req,
   output var  logic [7:0]                reg_rdata,
   input  wire logic                      rx_lock,
   input  wire logic                      ten_bit_raw_mode,
   input  wire logic                      line_valid_strobe,
   input  wire logic                      frame_valid_strobe,
   input  wire logic                      pix_valid,
   input  wire logic [9:0]                pix_data,
   output var  logic                      pix_ready,
   input  wire logic                      parity_fault,
   input  wire logic                      packet_error,
   output var  logic                      out_valid,
   input  wire logic                      out_ready,
   output var  rx_qual_pkg::pixel_word_t  out_word,
   output var  logic                      port_qualified,
   output var  logic [LEN_W-1:0]          line_length_readback,
   output var  logic [LEN_W-1:0]          line_count_readback
);
   import rx_qual_pkg::*;

   logic [7:0]       port_select;
   logic [7:0]       video_config;
   logic [7:0]       qual_control;
   logic [7:0]       packet_error_tally;
   logic             hit;
   logic             tally_read;
   frame_state_t     state;
   logic             fv_idle;
   logic             lv_idle;
   logic             learning;
   logic             learn_seen;
   logic             auto_q;
   logic             lock_q;
   logic             fv_inv;
   logic             lv_inv;
   logic             fv_act;
   logic             lv_act;
   logic             fv_act_q;
   logic             lv_act_q;
   logic             frame_start;
   logic             frame_end;
   logic             line_end;
   logic [LEN_W-1:0] len_cnt;
   logic [LEN_W-1:0] last_len;
   logic             have_len;
   logic [LEN_W-1:0] line_cnt;
   logic [LEN_W-1:0] last_lines;
   logic             have_lines;
   logic             line_change;
   logic             frame_change;
   logic             fault_now;
   logic             frame_good;
   logic [1:0]       good_frames;
   logic [1:0]       threshold;
   logic             first_pix;
   logic             first_line_pix;
   logic             fwd_ok;
   logic             fifo_in_valid;
   logic             fifo_in_ready;
   logic             narrow;
   pixel_word_t      in_word;
   logic [$bits(pixel_word_t)-1:0] fifo_out;

   function automatic logic [9:0] narrow_pixel(input logic [1:0] sel, input logic [9:0] pix);
      narrow_pixel = (sel == NARROW_UPPER) ? {2'b00, pix[9:2]} : {2'b00, pix[7:0]};
   endfunction

   // register access
   assign hit = port_select[PORT_INDEX];
   assign tally_read = reg_req.rd & hit & (reg_req.addr == ERR_TALLY_ADDR);
   assign threshold = qual_control[THRESH_HI:THRESH_LO];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         port_select <= PORT_SELECT_RESET;
         video_config <= VIDEO_CONFIG_RESET;
         qual_control <= QUAL_CONTROL_RESET;
      end else if (reg_req.wr) begin
         if (reg_req.addr == PORT_SELECT_ADDR) port_select <= reg_req.wdata;
         if (hit && reg_req.addr == VIDEO_CONFIG_ADDR) video_config <= reg_req.wdata;
         if (hit && reg_req.addr == QUAL_CONTROL_ADDR) qual_control <= reg_req.wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         if (reg_req.addr == PORT_SELECT_ADDR) reg_rdata <= port_select;
         else if (!hit) reg_rdata <= 8'h00;
         else if (reg_req.addr == ERR_TALLY_ADDR) reg_rdata <= packet_error_tally;
         else if (reg_req.addr == VIDEO_CONFIG_ADDR) reg_rdata <= video_config;
         else if (reg_req.addr == QUAL_CONTROL_ADDR) reg_rdata <= qual_control;
         else reg_rdata <= 8'h00;
      end
   end

   // error tally: an error in the read cycle survives the clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         packet_error_tally <= 8'h00;
      end else if (tally_read) begin
         packet_error_tally <= packet_error ? 8'h01 : 8'h00;
      end else if (packet_error && packet_error_tally != TALLY_MAX) begin
         packet_error_tally <= packet_error_tally + 8'h01;
      end
   end

   // polarity learning; entering mid-frame mislearns, the next relock retries
   // a real start must be seen first: the switch to learned sense can fake one short frame
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         auto_q <= 1'b0;
         lock_q <= 1'b0;
         learning <= 1'b0;
         learn_seen <= 1'b0;
         fv_idle <= 1'b0;
         lv_idle <= 1'b0;
      end else begin
         auto_q <= video_config[AUTO_SENSE];
         lock_q <= rx_lock;
         if (video_config[AUTO_SENSE] && (!auto_q || (rx_lock && !lock_q))) begin
            learning <= 1'b1;
            learn_seen <= 1'b0;
            fv_idle <= frame_valid_strobe;
            lv_idle <= line_valid_strobe;
         end else if (!video_config[AUTO_SENSE]) begin
            learning <= 1'b0;
         end else if (learning && frame_start) begin
            learn_seen <= 1'b1;
            lv_idle <= line_valid_strobe;
         end else if (learning && frame_end && learn_seen) begin
            learning <= 1'b0;
         end
      end
   end

   assign fv_inv = video_config[AUTO_SENSE] ? fv_idle : video_config[FRAME_SENSE];
   assign lv_inv = video_config[AUTO_SENSE] ? lv_idle : video_config[LINE_SENSE];
   assign fv_act = frame_valid_strobe ^ fv_inv;
   assign lv_act = line_valid_strobe ^ lv_inv;
   assign frame_start = fv_act & ~fv_act_q;
   assign frame_end = ~fv_act & fv_act_q;
   assign line_end = ~lv_act & lv_act_q & fv_act;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fv_act_q <= 1'b0;
         lv_act_q <= 1'b0;
      end else begin
         fv_act_q <= fv_act;
         lv_act_q <= lv_act;
      end
   end

   // line and frame metrics
   assign line_change = line_end & have_len & (len_cnt != last_len);
   assign frame_change = frame_end & have_lines & (line_cnt != last_lines);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         len_cnt <= '0;
         last_len <= '0;
         have_len <= 1'b0;
      end else if (line_end) begin
         len_cnt <= '0;
         last_len <= len_cnt;
         have_len <= 1'b1;
      end else if (pix_valid && fifo_in_ready && lv_act && fv_act) begin
         len_cnt <= len_cnt + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         line_cnt <= '0;
         last_lines <= '0;
         have_lines <= 1'b0;
      end else if (frame_start) begin
         line_cnt <= '0;
      end else if (frame_end) begin
         last_lines <= line_cnt;
         have_lines <= 1'b1;
      end else if (line_end) begin
         line_cnt <= line_cnt + 1'b1;
      end
   end

   // truncation
   assign fault_now = (parity_fault & video_config[PARITY_DROP])
                    | (line_change & video_config[LINE_DROP])
                    | (frame_change & video_config[FRAME_DROP]);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= FRAME_IDLE;
      end else begin
         unique case (state)
            FRAME_IDLE: begin
               if (frame_start) state <= FRAME_ACTIVE;
            end
            FRAME_ACTIVE: begin
               if (frame_end) state <= FRAME_IDLE;
               else if (fault_now) state <= FRAME_TRUNC;
            end
            FRAME_TRUNC: begin
               if (frame_start) state <= FRAME_ACTIVE;
            end
            default: state <= FRAME_IDLE;
         endcase
      end
   end

   // qualification
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         frame_good <= 1'b0;
         good_frames <= 2'b00;
      end else if (!rx_lock) begin
         frame_good <= 1'b0;
         good_frames <= 2'b00;
      end else if (frame_change && video_config[FRAME_DROP]) begin
         frame_good <= 1'b0;
         good_frames <= 2'b00;
      end else if (frame_start) begin
         frame_good <= 1'b1;
      end else if (fault_now) begin
         frame_good <= 1'b0;
      end else if (frame_end && frame_good) begin
         frame_good <= 1'b0;
         if (good_frames != 2'b11) good_frames <= good_frames + 2'b01;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         port_qualified <= 1'b0;
      end else begin
         port_qualified <= rx_lock & ((threshold == 2'b00) | (good_frames >= threshold));
      end
   end

   // metrics readback gated by qualification
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         line_length_readback <= '0;
         line_count_readback <= '0;
      end else if (qual_control[ZERO_METRICS] && !port_qualified) begin
         line_length_readback <= '0;
         line_count_readback <= '0;
      end else begin
         line_length_readback <= last_len;
         line_count_readback <= last_lines;
      end
   end

   // forwarding path
   assign fwd_ok = (state == FRAME_ACTIVE) & fv_act & lv_act & ~learning & ~fault_now
                 & ~frame_start & ~(qual_control[QUAL_DROP] & ~port_qualified);
   assign fifo_in_valid = pix_valid & fwd_ok;
   assign narrow = ten_bit_raw_mode & video_config[NARROW_HI];

   always_comb begin
      in_word.sof = first_pix;
      in_word.sol = first_line_pix | (lv_act & ~lv_act_q);
      in_word.eight_bit = narrow;
      in_word.data = narrow ? narrow_pixel(video_config[NARROW_HI:NARROW_LO], pix_data) : pix_data;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         first_pix <= 1'b0;
         first_line_pix <= 1'b0;
      end else begin
         if (frame_start) first_pix <= 1'b1;
         else if (fifo_in_valid && fifo_in_ready) first_pix <= 1'b0;
         if (fifo_in_valid && fifo_in_ready) first_line_pix <= 1'b0;
         else if (lv_act && !lv_act_q) first_line_pix <= 1'b1;
      end
   end

   // the source stalls on a full fifo, so pixels are never lost to back-pressure
   video_fifo #(
      .WIDTH ($bits(pixel_word_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (in_word),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (fifo_out)
   );

   assign pix_ready = fifo_in_ready;
   assign out_word = pixel_word_t'(fifo_out);

   // checks
   chk_tally_saturates: assert property (@(posedge clock) disable iff (rst)
      packet_error_tally == TALLY_MAX && packet_error && !tally_read |=> packet_error_tally == TALLY_MAX)
      else $error("error tally wrapped");
   chk_tally_read_clears: assert property (@(posedge clock) disable iff (rst)
      tally_read && !packet_error |=> packet_error_tally == 8'h00 && $past(packet_error_tally) == reg_rdata)
      else $error("tally read did not return and clear");
   chk_parity_truncates: assert property (@(posedge clock) disable iff (rst)
      state == FRAME_ACTIVE && parity_fault && video_config[PARITY_DROP] && !frame_end
      |=> state == FRAME_TRUNC)
      else $error("parity error did not truncate");
   chk_trunc_no_forward: assert property (@(posedge clock) disable iff (rst)
      state == FRAME_TRUNC && !frame_start |-> !fifo_in_valid)
      else $error("pixel pushed in truncated frame");
   chk_qual_drop: assert property (@(posedge clock) disable iff (rst)
      fifo_in_valid && qual_control[QUAL_DROP] |-> port_qualified)
      else $error("pixel forwarded while unqualified");
   chk_zero_metrics: assert property (@(posedge clock) disable iff (rst)
      qual_control[ZERO_METRICS] && !port_qualified |=> line_length_readback == '0 && line_count_readback == '0)
      else $error("metrics not zeroed");
   chk_lock_qualifies: assert property (@(posedge clock) disable iff (rst)
      threshold == 2'b00 && rx_lock ##1 threshold == 2'b00 && rx_lock |=> port_qualified)
      else $error("lock did not qualify at zero threshold");
   chk_narrow_upper: assert property (@(posedge clock) disable iff (rst)
      fifo_in_valid && ten_bit_raw_mode && video_config[NARROW_HI:NARROW_LO] == NARROW_UPPER
      |-> in_word.data == {2'b00, pix_data[9:2]} && in_word.eight_bit)
      else $error("upper narrowing wrong");
   chk_learn_drops: assert property (@(posedge clock) disable iff (rst)
      learning |-> !fifo_in_valid)
      else $error("pixel forwarded while learning polarity");
   chk_fixed_sense: assert property (@(posedge clock) disable iff (rst)
      !video_config[AUTO_SENSE] |-> fv_inv == video_config[FRAME_SENSE] && lv_inv == video_config[LINE_SENSE])
      else $error("fixed polarity not used");
endmodule // rx_port_video_qualifier
`default_nettype wire

// ==== video_source_model.sv ====
// behavioural model of the remote serializer feeding raw video into one receive port
// assumes the bench owns lock and packet error; pixels wait on pix_ready at rising edges
`timescale 1ns/1ps
`default_nettype none
module video_source_model (
   input  wire logic       clock,
   input  wire logic       pix_ready,
   output var  logic       line_valid_strobe,
   output var  logic       frame_valid_strobe,
   output var  logic       pix_valid,
   output var  logic [9:0] pix_data,
   output var  logic       parity_fault
);
   initial begin
      line_valid_strobe  = 1'b0;
      frame_valid_strobe = 1'b0;
      pix_valid          = 1'b0;
      pix_data           = 10'h155;
      parity_fault       = 1'b0;
   end

   // inactive levels for the given sense, held long enough to be seen as idle
   task automatic idle(input logic inv);
      @(posedge clock);
      frame_valid_strobe <= inv;
      line_valid_strobe  <= inv;
      repeat (3) @(posedge clock);
   endtask

   // uniform frame; a parity pulse lands in the gap after line par_line
   task automatic send_frame(input int lines, input int len, input logic inv, input int par_line,
                             output int stalls);
      int         w;
      logic [9:0] v;
      stalls = 0;
      v      = 10'h3c5;
      idle(inv);
      frame_valid_strobe <= ~inv;
      repeat (2) @(posedge clock);
      for (int l = 0; l < lines; l++) begin
         for (int k = 0; k < len; k++) begin
            line_valid_strobe <= ~inv;
            pix_valid         <= 1'b1;
            pix_data          <= v;
            v = v + 10'h001;
            w = 0;
            do begin
               @(posedge clock);
               w++;
            end while (pix_ready !== 1'b1 && w < 60);
            if (pix_ready !== 1'b1) stalls++;
         end
         // released data toggles so a stale value is never mistaken for a pixel
         pix_valid         <= 1'b0;
         pix_data          <= ~v;
         line_valid_strobe <= inv;
         @(posedge clock);
         parity_fault <= (l == par_line);
         @(posedge clock);
         parity_fault <= 1'b0;
         @(posedge clock);
      end
      frame_valid_strobe <= inv;
      repeat (4) @(posedge clock);
   endtask
endmodule // video_source_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the receive port video qualifier
// assumes this instance is port 0 and the source model drives the video side
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
   import rx_qual_pkg::*;
   logic        clock, rst, rx_lock, raw_mode, packet_error, out_ready, out_valid, port_qualified;
   logic        lv, fv, pix_valid, pix_ready, parity_fault;
   logic [9:0]  pix_data;
   logic [7:0]  reg_rdata, d;
   logic [15:0] line_len, line_cnt;
   reg_req_t    req;
   pixel_word_t out_word;
   pixel_word_t q[$];
   int          n_fail = 0, comparisons = 0, stalls;
   logic [7:0]  cfg[3] = '{8'h60, 8'ha0, 8'he0};
   logic [7:0]  exp_d[3] = '{8'hc5, 8'hf1, 8'hc5};

   rx_port_video_qualifier rx_port_video_qualifier_inst (.clock(clock), .rst(rst), .reg_req(req),
      .reg_rdata(reg_rdata), .rx_lock(rx_lock), .ten_bit_raw_mode(raw_mode), .line_valid_strobe(lv),
      .frame_valid_strobe(fv), .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
      .parity_fault(parity_fault), .packet_error(packet_error), .out_valid(out_valid),
      .out_ready(out_ready), .out_word(out_word), .port_qualified(port_qualified),
      .line_length_readback(line_len), .line_count_readback(line_cnt));
   video_source_model video_source_model_inst (.clock(clock), .pix_ready(pix_ready),
      .line_valid_strobe(lv), .frame_valid_strobe(fv), .pix_valid(pix_valid), .pix_data(pix_data),
      .parity_fault(parity_fault));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   always @(posedge clock) if (out_valid === 1'b1 && out_ready === 1'b1) q.push_back(out_word);

   task automatic end_sim;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clock);
      req.wr <= 1'b0;
   endtask

   // read data is registered on the same edge that takes the strobe, then holds
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clock);
      req.rd <= 1'b0;
      @(posedge clock);
      d = reg_rdata;
      `CHK("register read", e, d)
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clock);
         packet_error <= 1'b1;
         @(posedge clock);
         packet_error <= 1'b0;
      end
   endtask

   task automatic frame(input int lines, input int len, input logic inv, input int par, input int n);
      q.delete();
      video_source_model_inst.send_frame(lines, len, inv, par, stalls);
      repeat (12) @(posedge clock);
      `CHK("forwarded pixels", n, q.size())
      `CHK("source stalls", 0, stalls)
   endtask

   initial begin
      rst = 1'b1;
      req = '0;
      rx_lock = 1'b0;
      raw_mode = 1'b1;
      packet_error = 1'b0;
      out_ready = 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      rchk(PORT_SELECT_ADDR, 8'h01);
      rchk(VIDEO_CONFIG_ADDR, 8'h20);
      rchk(QUAL_CONTROL_ADDR, 8'h00);
      rchk(ERR_TALLY_ADDR, 8'h00);
      rchk(8'h80, 8'h00);
      wr(VIDEO_CONFIG_ADDR, 8'h5a);
      rchk(VIDEO_CONFIG_ADDR, 8'h5a);
      wr(ERR_TALLY_ADDR, 8'h33);
      rchk(ERR_TALLY_ADDR, 8'h00);
      wr(PORT_SELECT_ADDR, 8'h02);
      wr(VIDEO_CONFIG_ADDR, 8'h20);
      rchk(VIDEO_CONFIG_ADDR, 8'h00);
      wr(PORT_SELECT_ADDR, 8'h01);
      rchk(VIDEO_CONFIG_ADDR, 8'h5a);
      pulses(3);
      rchk(ERR_TALLY_ADDR, 8'h03);
      rchk(ERR_TALLY_ADDR, 8'h00);
      pulses(260);
      rchk(ERR_TALLY_ADDR, TALLY_MAX);
      wr(VIDEO_CONFIG_ADDR, 8'h20);
      `CHK("qualified before lock", 1'b0, port_qualified)
      rx_lock <= 1'b1;
      repeat (3) @(posedge clock);
      `CHK("qualified after lock", 1'b1, port_qualified)
      frame(2, 4, 1'b0, -1, 8);
      `CHK("frame start flag", 1'b1, q[0].sof)
      `CHK("line start flag", 1'b1, q[4].sol)
      `CHK("ten bit pixel", 10'h3c5, q[0].data)
      `CHK("line length", 16'd4, line_len)
      `CHK("line count", 16'd2, line_cnt)
      for (int i = 0; i < 3; i++) begin
         wr(VIDEO_CONFIG_ADDR, cfg[i]);
         frame(1, 4, 1'b0, -1, 4);
         `CHK("eight bit flag", (i != 0), q[0].eight_bit)
         `CHK("narrowed pixel", exp_d[i], q[0].data[7:0])
      end
      wr(VIDEO_CONFIG_ADDR, 8'h20);
      frame(2, 4, 1'b0, 0, 4);
      wr(VIDEO_CONFIG_ADDR, 8'h00);
      frame(2, 4, 1'b0, 0, 8);
      // sink stalls so the fifo fills and pushes back on the source
      wr(VIDEO_CONFIG_ADDR, 8'h20);
      out_ready <= 1'b0;
      fork
         frame(1, 6, 1'b0, -1, 6);
         begin
            repeat (25) @(posedge clock);
            `CHK("fifo full refusal", 1'b0, pix_ready)
            out_ready <= 1'b1;
         end
      join
      `CHK("order after stall", 10'h3ca, q[5].data)
      wr(QUAL_CONTROL_ADDR, 8'hc2);
      rx_lock <= 1'b0;
      repeat (2) @(posedge clock);
      rx_lock <= 1'b1;
      repeat (2) @(posedge clock);
      `CHK("qualified with threshold", 1'b0, port_qualified)
      frame(2, 4, 1'b0, -1, 0);
      `CHK("gated line length", 16'd0, line_len)
      frame(2, 4, 1'b0, -1, 0);
      `CHK("qualified after frames", 1'b1, port_qualified)
      frame(2, 4, 1'b0, -1, 8);
      `CHK("ungated line length", 16'd4, line_len)
      wr(VIDEO_CONFIG_ADDR, 8'h28);
      frame(1, 4, 1'b0, -1, 4);
      `CHK("qualified after size change", 1'b0, port_qualified)
      wr(QUAL_CONTROL_ADDR, 8'h00);
      wr(VIDEO_CONFIG_ADDR, 8'h30);
      frame(2, 5, 1'b0, -1, 5);
      video_source_model_inst.idle(1'b1);
      wr(VIDEO_CONFIG_ADDR, 8'h23);
      frame(2, 4, 1'b1, -1, 8);
      wr(VIDEO_CONFIG_ADDR, 8'h24);
      frame(2, 4, 1'b1, -1, 0);
      frame(2, 4, 1'b1, -1, 8);
      end_sim();
   end

   initial begin
      repeat (100000) @(posedge clock);
      n_fail++;
      $display("CHECK FAILED run length expected finish seen timeout");
      end_sim();
   end
endmodule // tb
`undef CHK
`default_nettype wire
